// >>> include/hrcp_pkg.sv
package hrcp_pkg;

   // ******************************************
   // character codes seen on the serial stream
   // ******************************************
   localparam logic [7:0] CH_COLON = 8'h3a;
   localparam logic [7:0] CH_SEMI  = 8'h3b;
   localparam logic [7:0] CH_CR    = 8'h0d;
   localparam logic [7:0] CH_LF    = 8'h0a;
   localparam logic [7:0] CH_NUL   = 8'h00;
   localparam logic [7:0] CH_SP    = 8'h20;
   localparam logic [7:0] CH_STAR  = 8'h2a;
   localparam logic [7:0] CH_OK    = 8'h21;
   localparam logic [7:0] CH_BAD   = 8'h3f;
   localparam logic [7:0] CKS_WILD = 8'hff;

   // ******************************************
   // record types (commands)
   // ******************************************
   localparam logic [7:0] T_CE_WR0 = 8'h00;
   localparam logic [7:0] T_EOF    = 8'h01;
   localparam logic [7:0] T_CE_WR2 = 8'h02;
   localparam logic [7:0] T_CE_RD  = 8'h03;
   localparam logic [7:0] T_MPU_WR = 8'h04;
   localparam logic [7:0] T_MPU_RD = 8'h05;
   localparam logic [7:0] T_RTC_WR = 8'h06;
   localparam logic [7:0] T_RTC_RD = 8'h07;
   localparam logic [7:0] T_SFR_WR = 8'h08;
   localparam logic [7:0] T_SFR_RD = 8'h09;

   // ******************************************
   // address map and record layout
   // ******************************************
   localparam logic [15:0] CE_BASE   = 16'h1000;
   localparam logic [15:0] IO_BASE   = 16'h2000;
   localparam int          MAX_BYTES = 32;
   localparam logic [6:0]  IDX_COUNT = 7'h00;
   localparam logic [6:0]  IDX_AHI   = 7'h01;
   localparam logic [6:0]  IDX_ALO   = 7'h02;
   localparam logic [6:0]  IDX_TYPE  = 7'h03;
   localparam logic [6:0]  IDX_DATA  = 7'h04;

   // ******************************************
   // timing
   // ******************************************
   localparam int CLK_NS        = 8;
   localparam int TICK_NS       = 1000000;
   localparam int TICK_CYCLES   = TICK_NS / CLK_NS;
   localparam int TIMEOUT_S     = 30;
   localparam int TIMEOUT_TICKS = TIMEOUT_S * 1000;

   // ******************************************
   // memory access carrier
   // ******************************************
   typedef enum logic [1:0] {
      SP_CE  = 2'h0,
      SP_MPU = 2'h1,
      SP_RTC = 2'h2,
      SP_SFR = 2'h3
   } hrcp_space_t;

   typedef struct packed {
      logic        vld;
      logic        wr;
      hrcp_space_t space;
      logic [15:0] addr;
      logic [7:0]  data;
   } hrcp_mem_req_t;

endpackage

// >>> design/hrcp_timeout.sv
`timescale 1ns/1ns
module hrcp_timeout #(
   parameter int TICK_CYC  = 125000,
   parameter int TICKS     = 30000
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic run,
   input  wire logic restart,
   output logic      expire
);
   logic [31:0] div_q;
   logic [31:0] tick_cnt_q;
   logic        tick_q;
   logic        expire_q;

   assign expire = expire_q;

   // ******************************************
   // ms enable divider, held in reset while idle
   // ******************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q  <= 32'h0;
         tick_q <= 1'b0;
      end else if (!run || restart || div_q == 32'(TICK_CYC - 1)) begin
         div_q  <= 32'h0;
         tick_q <= run && !restart;
      end else begin
         div_q  <= div_q + 32'h1;
         tick_q <= 1'b0;
      end
   end

   // tick counter; expire is a single pulse at the count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= 32'h0;
         expire_q   <= 1'b0;
      end else if (!run || restart) begin
         tick_cnt_q <= 32'h0;
         expire_q   <= 1'b0;
      end else begin
         expire_q <= tick_q && tick_cnt_q == 32'(TICKS - 1);
         if (tick_q) begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
         end
      end
   end
endmodule

// >>> design/hrcp_parser.sv
// Contract
// - a colon always starts a new record; a colon that arrives while a record is executed or answered is dropped
// - two hex characters give the data byte count
// - four hex characters give the 16-bit physical address
// - each byte is two hex characters, high nibble first
// - data buffer holds at least 32 bytes
// - checksum is two's complement of the byte sum, verified
// - checksum FF is a wild card, comparison skipped
// - CR, LF or NUL after a record are accepted and ignored
// - types 00 and 02 write CE data RAM, based at 0x1000
// - type 01 must be :00000001FF and commits data to storage
// - type 03 reads CE data RAM and returns it
// - type 04 writes processor or I/O RAM
// - type 05 reads processor or I/O RAM; I/O RAM at 0x2000
// - type 06 writes, type 07 reads RTC space
// - type 08 writes SFRs with upper address zero; 09 reads SFRs
// - larger variant answers CR LF with an asterisk
// - smaller variant answers CR LF with LF then asterisk
// - smaller variant repeats the last command on a semicolon
// - engine halted with greeting until stored or serial data arrives
// - switch command enters hex mode; only reset leaves it
// - accepted record answers '!', rejected answers '?'
// - incomplete record for about 30 s is dropped, CR LF sent
// - spaces between fields are ignored
`timescale 1ns/1ns
module hrcp_parser
   import hrcp_pkg::*;
#(
   parameter bit SMALL       = 1'b0,
   parameter bit HAS_TEXT_IF = 1'b0,
   parameter int BUF_BYTES   = hrcp_pkg::MAX_BYTES,
   parameter int TICK_CYC    = hrcp_pkg::TICK_CYCLES,
   parameter int TMO_TICKS   = hrcp_pkg::TIMEOUT_TICKS
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_byte,
   output logic                   tx_valid,
   output logic [7:0]             tx_byte,
   input  wire logic              tx_ready,
   output hrcp_pkg::hrcp_mem_req_t mem_req,
   input  wire logic              mem_ack,
   input  wire logic [7:0]        mem_rdata,
   output logic                   nv_commit,
   input  wire logic              nv_load_done,
   input  wire logic              nv_load_ok,
   output logic                   engine_run,
   output logic                   greeting_prompt,
   input  wire logic              hex_mode_switch_command,
   output logic                   hex_mode
);
   import hrcp_pkg::*;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_REC  = 5'b00010,
      S_REQ  = 5'b00100,
      S_ACK  = 5'b01000,
      S_FIN  = 5'b10000
   } hrcp_state_t;

   // ******************************************
   // character decoding functions
   // ******************************************
   function automatic logic is_hex(input logic [7:0] c);
      return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
             (c >= 8'h61 && c <= 8'h66);
   endfunction

   function automatic logic [3:0] hex_val(input logic [7:0] c);
      logic [7:0] v;
      v = (c <= 8'h39) ? c - 8'h30 : (c <= 8'h46) ? c - 8'h37 : c - 8'h57;
      return v[3:0];
   endfunction

   function automatic logic [7:0] to_asc(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   // ******************************************
   // state
   // ******************************************
   hrcp_state_t   state_q;
   logic [7:0]    buf_q [BUF_BYTES];
   logic          hi_pend_q;
   logic [3:0]    hi_q;
   logic [6:0]    idx_q;
   logic [7:0]    cnt_q;
   logic [15:0]   addr_q;
   logic [7:0]    tp_q;
   logic [7:0]    sum_q;
   logic [7:0]    ptr_q;
   logic          last_vld_q;
   logic          prev_cr_q;
   logic [15:0]   resp_q;
   logic [1:0]    resp_n_q;
   logic [15:0]   pend_q;
   logic [1:0]    pend_n_q;
   logic          tx_valid_q;
   logic [7:0]    tx_byte_q;
   hrcp_mem_req_t mem_req_q;
   logic          nv_commit_q;
   logic          engine_run_q;
   logic          greeting_q;
   logic          hex_mode_q;
   logic          tmo_expire;

   assign tx_valid        = tx_valid_q;
   assign tx_byte         = tx_byte_q;
   assign mem_req         = mem_req_q;
   assign nv_commit       = nv_commit_q;
   assign engine_run      = engine_run_q;
   assign greeting_prompt = greeting_q;
   assign hex_mode        = hex_mode_q;

   // ******************************************
   // record decode
   // ******************************************
   wire        rx_go    = rx_valid && hex_mode_q;
   wire        rx_hex   = is_hex(rx_byte);
   wire [7:0]  byte_w   = {hi_q, hex_val(rx_byte)};
   wire        byte_done = rx_go && state_q == S_REC && rx_hex && hi_pend_q;
   // read records carry an empty data field, so their count sizes the read only
   wire        is_cks   = idx_q == IDX_DATA + (tp_rd ? 7'h00 : cnt_q[6:0]);
   wire        cks_ok   = (sum_q + byte_w == 8'h00) || byte_w == CKS_WILD;
   wire        tp_rd    = tp_q[0] && tp_q != T_EOF;
   wire        tp_eof   = tp_q == T_EOF;
   wire        tp_cewr  = tp_q == T_CE_WR0 || tp_q == T_CE_WR2;
   wire        hdr_ok   = tp_q <= T_SFR_RD &&
                          (tp_q != T_SFR_WR || addr_q[15:8] == 8'h00) &&
                          (!tp_eof || (cnt_q == 8'h00 && addr_q == 16'h0));
   wire [7:0]  n_acc    = tp_eof ? 8'h00 : (tp_rd && cnt_q == 8'h00) ? 8'h01 : cnt_q;
   wire        rec_good = byte_done && is_cks && cks_ok && hdr_ok;
   wire        bad_char = rx_go && state_q == S_REC && !rx_hex &&
                          rx_byte != CH_SP && rx_byte != CH_COLON;
   wire [15:0] acc_addr = addr_q + {8'h00, ptr_q};
   // CE offsets below the RAM base are taken as relative to it
   wire [15:0] ce_addr  = (acc_addr < CE_BASE) ? acc_addr + CE_BASE : acc_addr;
   wire        fin_ld   = state_q == S_FIN && pend_n_q == 2'h0;
   wire        rd_ld    = state_q == S_ACK && mem_ack && !mem_req_q.wr;

   // ******************************************
   // partial record timeout
   // ******************************************
   hrcp_timeout #(
      .TICK_CYC (TICK_CYC),
      .TICKS    (TMO_TICKS)
   ) u_tmo (
      .clk     (clk),
      .rst_n   (rst_n),
      .run     (state_q == S_REC),
      .restart (rx_go),
      .expire  (tmo_expire)
   );

   // ******************************************
   // main sequencer
   // ******************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= S_IDLE;
         hi_pend_q  <= 1'b0;
         hi_q       <= 4'h0;
         idx_q      <= 7'h0;
         cnt_q      <= 8'h0;
         addr_q     <= 16'h0;
         tp_q       <= 8'h0;
         sum_q      <= 8'h0;
         ptr_q      <= 8'h0;
         last_vld_q <= 1'b0;
         prev_cr_q  <= 1'b0;
         resp_q     <= 16'h0;
         resp_n_q   <= 2'h0;
         mem_req_q  <= '0;
         nv_commit_q <= 1'b0;
      end else begin
         nv_commit_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (rx_go) begin
                  prev_cr_q <= rx_byte == CH_CR;
                  if (rx_byte == CH_COLON) begin
                     state_q    <= S_REC;
                     last_vld_q <= 1'b0;
                     {hi_pend_q, idx_q, sum_q} <= '0;
                  end else if (SMALL && rx_byte == CH_SEMI && last_vld_q) begin
                     state_q <= S_REQ;
                     ptr_q   <= 8'h0;
                  end else if (rx_byte == CH_LF && prev_cr_q) begin
                     state_q  <= S_FIN;
                     resp_q   <= SMALL ? {CH_LF, CH_STAR} : {CH_STAR, 8'h00};
                     resp_n_q <= SMALL ? 2'h2 : 2'h1;
                  end
                  // CR, LF and NUL otherwise fall through quietly
               end
            end
            S_REC: begin
               if (tmo_expire) begin
                  state_q  <= S_FIN;
                  resp_q   <= {CH_CR, CH_LF};
                  resp_n_q <= 2'h2;
               end else if (rx_go && rx_byte == CH_COLON) begin
                  {hi_pend_q, idx_q, sum_q} <= '0;
               end else if (bad_char) begin
                  state_q  <= S_FIN;
                  resp_q   <= {CH_BAD, 8'h00};
                  resp_n_q <= 2'h1;
               end else if (rx_go && rx_hex && !hi_pend_q) begin
                  hi_q      <= hex_val(rx_byte);
                  hi_pend_q <= 1'b1;
               end else if (byte_done) begin
                  hi_pend_q <= 1'b0;
                  idx_q     <= idx_q + 7'h1;
                  sum_q     <= sum_q + byte_w;
                  if (idx_q == IDX_COUNT) begin
                     cnt_q <= byte_w;
                     if (byte_w > 8'(BUF_BYTES)) begin
                        state_q  <= S_FIN;
                        resp_q   <= {CH_BAD, 8'h00};
                        resp_n_q <= 2'h1;
                     end
                  end else if (idx_q == IDX_AHI) begin
                     addr_q[15:8] <= byte_w;
                  end else if (idx_q == IDX_ALO) begin
                     addr_q[7:0] <= byte_w;
                  end else if (idx_q == IDX_TYPE) begin
                     tp_q <= byte_w;
                  end else if (is_cks) begin
                     state_q    <= rec_good ? S_REQ : S_FIN;
                     last_vld_q <= rec_good;
                     ptr_q      <= 8'h0;
                     resp_q     <= {CH_BAD, 8'h00};
                     resp_n_q   <= 2'h1;
                  end
               end
            end
            S_REQ: begin
               if (ptr_q == n_acc) begin
                  state_q     <= S_FIN;
                  resp_q      <= {CH_OK, 8'h00};
                  resp_n_q    <= 2'h1;
                  nv_commit_q <= tp_eof;
               end else if (pend_n_q == 2'h0) begin
                  state_q         <= S_ACK;
                  mem_req_q.vld   <= 1'b1;
                  mem_req_q.wr    <= !tp_rd;
                  mem_req_q.space <= (tp_q <= T_CE_RD) ? SP_CE :
                                     (tp_q <= T_MPU_RD) ? SP_MPU :
                                     (tp_q <= T_RTC_RD) ? SP_RTC : SP_SFR;
                  mem_req_q.addr  <= (tp_q <= T_CE_RD) ? ce_addr : acc_addr;
                  mem_req_q.data  <= buf_q[ptr_q[4:0]];
               end
            end
            S_ACK: begin
               if (mem_ack) begin
                  mem_req_q.vld <= 1'b0;
                  ptr_q         <= ptr_q + 8'h1;
                  state_q       <= S_REQ;
               end
            end
            S_FIN: begin
               if (fin_ld) begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // data bytes land in the buffer as they complete
   always_ff @(posedge clk) begin
      if (byte_done && idx_q >= IDX_DATA && !is_cks) begin
         buf_q[5'(idx_q - IDX_DATA)] <= byte_w;
      end
   end

   // ******************************************
   // transmit: two-character holding register
   // ******************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q     <= 16'h0;
         pend_n_q   <= 2'h0;
         tx_valid_q <= 1'b0;
         tx_byte_q  <= 8'h0;
      end else if ((!tx_valid_q || tx_ready) && pend_n_q != 2'h0) begin
         tx_valid_q <= 1'b1;
         tx_byte_q  <= pend_q[15:8];
         pend_q     <= {pend_q[7:0], 8'h00};
         pend_n_q   <= pend_n_q - 2'h1;
      end else begin
         if (tx_ready) begin
            tx_valid_q <= 1'b0;
         end
         if (rd_ld) begin
            pend_q   <= {to_asc(mem_rdata[7:4]), to_asc(mem_rdata[3:0])};
            pend_n_q <= 2'h2;
         end else if (fin_ld) begin
            pend_q   <= resp_q;
            pend_n_q <= resp_n_q;
         end
      end
   end

   // ******************************************
   // start-up engine state and interface mode
   // ******************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         engine_run_q <= 1'b0;
         greeting_q   <= 1'b1;
         hex_mode_q   <= !HAS_TEXT_IF;
      end else begin
         if ((nv_load_done && nv_load_ok) ||
             (state_q == S_REQ && ptr_q == n_acc && tp_cewr && cnt_q != 8'h00)) begin
            engine_run_q <= 1'b1;
            greeting_q   <= 1'b0;
         end
         // sticky: only a reset brings back the text interface
         if (hex_mode_switch_command) begin
            hex_mode_q <= 1'b1;
         end
      end
   end

   // ******************************************
   // assertions
   // ******************************************
   property p_colon;
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_IDLE && rx_go && rx_byte == CH_COLON) |=> state_q == S_REC;
   endproperty
   a_colon: assert property (p_colon) else $error("colon did not open record");

   property p_badc;
      @(posedge clk) disable iff (!rst_n)
      (bad_char && !tmo_expire) |=> state_q == S_FIN && resp_q[15:8] == CH_BAD
         ##1 !mem_req_q.vld;
   endproperty
   a_badc: assert property (p_badc) else $error("bad character not rejected");

   property p_wild;
      @(posedge clk) disable iff (!rst_n)
      (byte_done && is_cks && byte_w == CKS_WILD && hdr_ok && !tmo_expire)
         |=> state_q == S_REQ;
   endproperty
   a_wild: assert property (p_wild) else $error("wild card checksum refused");

   property p_commit;
      @(posedge clk) disable iff (!rst_n)
      nv_commit_q |-> tp_q == T_EOF && cnt_q == 8'h00 && state_q == S_FIN;
   endproperty
   a_commit: assert property (p_commit) else $error("commit without eof record");

   property p_tmo;
      @(posedge clk) disable iff (!rst_n)
      (state_q == S_REC && tmo_expire) |=> resp_q == {CH_CR, CH_LF} ##[1:3] pend_n_q == 2'h2;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout did not send cr lf");

   property p_sfr;
      @(posedge clk) disable iff (!rst_n)
      (mem_req_q.vld && mem_req_q.space == SP_SFR && mem_req_q.wr)
         |-> mem_req_q.addr[15:8] == 8'h00;
   endproperty
   a_sfr: assert property (p_sfr) else $error("sfr write with upper address");

   property p_ce;
      @(posedge clk) disable iff (!rst_n)
      (mem_req_q.vld && mem_req_q.space == SP_CE) |-> mem_req_q.addr >= CE_BASE;
   endproperty
   a_ce: assert property (p_ce) else $error("ce access below ram base");

   property p_text;
      @(posedge clk) disable iff (!rst_n)
      !hex_mode_q |-> state_q == S_IDLE && !tx_valid_q;
   endproperty
   a_text: assert property (p_text) else $error("records parsed in text mode");
endmodule

// >>> testbench/hrcp_mem_model.sv
`timescale 1ns/1ns
module hrcp_mem_model
   import hrcp_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire hrcp_pkg::hrcp_mem_req_t mem_req,
   output logic                         mem_ack,
   output logic [7:0]                   mem_rdata
);
   import hrcp_pkg::*;
   int wait_q;
   int seed = 9;
   // ack after 0..3 cycles; read data toggles outside the ack so stale values never match
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack   <= 1'b0;
         mem_rdata <= 8'h00;
         wait_q    <= 0;
      end else if (mem_ack) begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wait_q    <= $random(seed) & 3;
      end else if (mem_req.vld && wait_q == 0) begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem_req.addr[7:0] ^ mem_req.addr[15:8] ^ 8'h5a;
      end else begin
         mem_rdata <= ~mem_rdata;
         if (mem_req.vld) wait_q <= wait_q - 1;
      end
   end
endmodule

// >>> testbench/hex_record_command_parser_test.sv
`timescale 1ns/1ns
module hex_record_command_parser_test;
   import hrcp_pkg::*;
   logic          clk, rst_n, rx_valid, tx_ready, mem_ack, nv_load_done, nv_load_ok, sw_cmd;
   logic [7:0]    rx_byte, tx_byte, mem_rdata;
   logic          tx_valid, nv_commit, engine_run, greeting_prompt, hex_mode;
   hrcp_mem_req_t mem_req;
   int            miscompares, cmp_count, cyc, commits, exp_commits, i;
   int            seed = 40;
   logic [7:0]    exp_tx[$], last_tx[$];
   logic [26:0]   exp_mem[$], last_mem[$];

   hrcp_parser #(.SMALL(1'b1), .HAS_TEXT_IF(1'b1), .BUF_BYTES(32), .TICK_CYC(4),
      .TMO_TICKS(5)) u_dut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
      .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .nv_commit(nv_commit),
      .nv_load_done(nv_load_done), .nv_load_ok(nv_load_ok), .engine_run(engine_run),
      .greeting_prompt(greeting_prompt), .hex_mode_switch_command(sw_cmd),
      .hex_mode(hex_mode));
   hrcp_mem_model u_mem (.clk(clk), .rst_n(rst_n), .mem_req(mem_req), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // sink stalls about a quarter of the time
   always @(negedge clk) tx_ready <= ($random(seed) & 3) != 0;

   // ************
   // result monitor
   // ************
   always @(posedge clk) begin
      cyc++;
      if (cyc > 60000) begin
         miscompares++;
         stop_test();
      end
      if (rst_n && tx_valid === 1'b1 && tx_ready)
         chk(tx_byte, exp_tx.size() ? exp_tx.pop_front() : 36'hf00000000, "tx");
      if (rst_n && mem_ack && mem_req.vld === 1'b1)
         chk({mem_req.wr, mem_req.space, mem_req.addr, mem_req.wr ? mem_req.data : 8'h00},
            exp_mem.size() ? exp_mem.pop_front() : 36'hf00000000, "mem");
      if (rst_n && nv_commit === 1'b1) commits++;
   end

   function automatic logic [7:0] hx(input logic [3:0] n);
      return n < 4'ha ? 8'h30 + n : 8'h37 + n;
   endfunction

   function automatic logic [7:0] rdf(input logic [15:0] x);
      return x[7:0] ^ x[15:8] ^ 8'h5a;
   endfunction

   task automatic put(input logic [7:0] c);
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte  = c;
      @(negedge clk);
      rx_valid = 1'b0;
   endtask

   task automatic put_b(input logic [7:0] b);
      put(hx(b[7:4]));
      put(hx(b[3:0]));
   endtask

   // waits for every expected answer, bounded; chars are dropped while answering
   task automatic settle();
      int k;
      for (k = 0; k < 3000 && (exp_tx.size() || exp_mem.size()); k++) @(negedge clk);
      chk(exp_tx.size() + exp_mem.size(), 0, "answer missing");
      repeat (4) @(negedge clk);
   endtask

   // mode 0 good checksum, 1 wild card, 2 wrong checksum
   task automatic rec(input logic [7:0] t, input logic [15:0] a, input int n, input int mode);
      logic [7:0]  d[$];
      logic [7:0]  lt[$];
      logic [26:0] lm[$];
      logic [7:0]  s, c, r;
      logic [15:0] ea;
      logic [1:0]  sp;
      logic        ok;
      int          k;
      s = n[7:0] + a[15:8] + a[7:0] + t;
      for (k = 0; k < (t[0] ? 0 : n); k++) begin
         d.push_back($random(seed));
         s += d[k];
      end
      ok = mode != 2 && t <= T_SFR_RD && !(t == T_SFR_WR && a[15:8] != 8'h00);
      ea = (t < 8'h04 && t != T_EOF && a < CE_BASE) ? a + CE_BASE : a;
      sp = t < 8'h04 ? 2'h0 : 2'(t[3:0] / 2 - 1);
      if (ok && t == T_EOF) exp_commits++;
      else if (ok && t[0]) begin
         for (k = 0; k < (n ? n : 1); k++) begin
            r = rdf(ea + k[15:0]);
            lm.push_back({1'b0, sp, ea + k[15:0], 8'h00});
            lt.push_back(hx(r[7:4]));
            lt.push_back(hx(r[3:0]));
         end
      end else if (ok) begin
         for (k = 0; k < n; k++) lm.push_back({1'b1, sp, ea + k[15:0], d[k]});
      end
      lt.push_back(ok ? CH_OK : CH_BAD);
      exp_tx  = {exp_tx, lt};
      exp_mem = {exp_mem, lm};
      if (ok) begin
         last_tx  = lt;
         last_mem = lm;
      end
      c = mode == 1 ? CKS_WILD : 8'h00 - s;
      if (mode == 2) c = (c ^ 8'h01) == CKS_WILD ? 8'h7e : c ^ 8'h01;
      put(CH_COLON);
      put_b(n[7:0]);
      put(CH_SP);
      put_b(a[15:8]);
      put_b(a[7:0]);
      put_b(t);
      for (k = 0; k < d.size(); k++) put_b(d[k]);
      put_b(c);
      settle();
   endtask

   // ************
   // main sequence
   // ************
   initial begin
      rst_n = 1'b0; rx_valid = 1'b0; rx_byte = 8'h00; tx_ready = 1'b1;
      nv_load_done = 1'b0; nv_load_ok = 1'b0; sw_cmd = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      chk(greeting_prompt, 1, "greeting");
      chk(hex_mode, 0, "text mode");
      put(CH_CR); put(CH_LF); put(CH_COLON); // text mode must stay silent
      nv_load_done = 1'b1;
      @(negedge clk);
      nv_load_done = 1'b0;
      sw_cmd = 1'b1;
      @(negedge clk);
      sw_cmd = 1'b0;
      repeat (3) @(negedge clk);
      chk(hex_mode, 1, "hex mode");
      chk(engine_run, 0, "halted on bad store");
      rec(T_CE_WR0, 16'h0008, 4, 0);
      chk({engine_run, greeting_prompt}, 2'b10, "engine run");
      for (i = 0; i < 10; i++) begin
         if (i != 1) begin
            rec(i[7:0], 16'($random(seed)), 1 + ($random(seed) & 3), 0);
         end
      end
      rec(T_CE_WR2, 16'h1010, 2, 1);
      rec(T_SFR_WR, 16'h0081, 2, 0);
      rec(T_SFR_WR, 16'h0181, 1, 0);
      rec(T_MPU_WR, IO_BASE, 32, 0);
      rec(T_RTC_WR, 16'h0010, 2, 2);
      rec(T_CE_RD, 16'h1020, 0, 0);
      rec(8'h0a, 16'h0000, 0, 0);
      rec(T_MPU_WR, 16'h2004, 1, 0);
      put(CH_NUL);
      exp_tx = {exp_tx, last_tx};
      exp_mem = {exp_mem, last_mem};
      put(CH_SEMI);
      settle();
      put(CH_COLON); put_b(8'h01); put(8'h47);
      exp_tx.push_back(CH_BAD);
      settle();
      put(CH_COLON); put_b(8'h21);
      exp_tx.push_back(CH_BAD);
      settle();
      put(CH_COLON); put_b(8'h05);
      rec(T_RTC_RD, 16'h0002, 2, 0);
      exp_tx = {exp_tx, CH_LF, CH_STAR};
      put(CH_CR); put(CH_LF);
      settle();
      exp_tx = {exp_tx, CH_CR, CH_LF};
      put(CH_COLON); put_b(8'h02);
      settle();
      rec(T_EOF, 16'h0000, 0, 0);
      chk(commits, exp_commits, "commit count");
      stop_test();
   end
endmodule
